// ==== mcc_clock_source_control.sv ====
`timescale 1ns/1ns
`default_nettype none
module mcc_clock_source_control
    import mcc_pkg::*;
(
    input  wire logic        clk_sys_i,             // 20 MHz system clock
    input  wire logic        rst_i,                 // Standby reset, high
    input  wire logic        ce_i,                  // Clock enable
    input  wire logic [15:0] mmcr_addr_i,           // Core register address
    input  wire logic [7:0]  mmcr_wdata_i,          // Core write data
    input  wire logic        mmcr_wr_i,             // Core write strobe
    input  wire logic        mmcr_rd_i,             // Core read strobe
    output logic      [7:0]  mmcr_rdata_o,          // Registered read data
    input  wire logic        main_power_good_i,     // Power-good pin
    input  wire logic        core_sleep_i,          // Core is in sleep
    input  wire logic        core_sleep_entry_i,    // Pulse: entering sleep
    input  wire logic        core_wake_i,           // Pulse: first wake
    input  wire logic        core_stopped_i,        // Core clock stopped
    input  wire logic        internal_reset_out_bit_i, // Reset-out bit
    input  wire logic        machine_cycle_i,       // Pulse per machine cycle
    input  wire logic        powergood_irq_clear_i, // Pulse: clear flag
    output logic             pll_clock_run_o,       // Core PLL clock runs
    output logic             pll_power_down_o,      // PLL powered down
    output logic             periph_clocks_run_o,   // Non-RTC clocks run
    output logic             pll_stable_o,          // PLL clocks settled
    output logic             ring_osc_on_o,         // Ring oscillator enable
    output logic             ring_osc_running_o,    // Ring oscillator up
    output logic             core_source_pll_o,     // Core mux: 1 = PLL
    output logic      [1:0]  core_freq_select_o,    // Core frequency code
    output logic             reset_out_pin_n_o,     // Reset-out pin, low
    output logic             internal_power_good_o, // Internal power-good
    output logic             power_fail_irq_o,      // Pulse: power failed
    output logic             powergood_irq_flag_o,  // Sticky flag, bit D0
    output logic             flash_to_core_o        // Core owns flash
);

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    mcc_clksel_t        clksel_r;
    mcc_clksel_t        clksel_nxt;
    logic [3:0]         reldly_r;
    logic [7:0]         rdata_r;
    logic [7:0]         rdata_nxt;
    logic               pg_s;
    logic               pg_prev_r;
    logic               rst_bit_prev_r;
    logic               down_prev_r;
    logic               ring_prev_r;
    logic               rst_pin_n_r;
    logic               pll_stable_r;
    logic               ring_run_r;
    logic               int_pg_r;
    logic               pfi_r;
    logic               pgi_r;
    logic               flash_r;
    mcc_fs_state_t      fs_state_r;
    mcc_fs_state_t      fs_state_nxt;
    logic [6:0]         fs_cnt_r;
    logic [6:0]         fs_cnt_nxt;
    logic               hit_clksel;
    logic               hit_reldly;
    logic               wr_clksel;
    logic               wr_reldly;
    logic               fail_evt;
    logic               fs_start;
    logic               fs_to_hand;
    logic               fs_hold;
    logic               rel_load;
    logic               rel_done;
    logic               lock_load;
    logic               lock_done;
    logic               ring_load;
    logic               ring_done;

    // ------------------------------------------------------------------
    // Pin synchroniser
    // ------------------------------------------------------------------
    mcc_sync2 u_pg_sync (
        .clk_sys_i (clk_sys_i),
        .rst_i     (rst_i),
        .ce_i      (ce_i),
        .d_i       (main_power_good_i),
        .q_o       (pg_s)
    );

    // ------------------------------------------------------------------
    // Register decode
    // ------------------------------------------------------------------
    // Address match and strobes
    assign hit_clksel = (mmcr_addr_i == MCC_ADDR_CLKSEL);
    assign hit_reldly = (mmcr_addr_i == MCC_ADDR_RELDLY);
    assign wr_clksel  = mmcr_wr_i && hit_clksel;
    assign wr_reldly  = mmcr_wr_i && hit_reldly;

    // Read mux; unmapped addresses read zero
    // reserved read zero
    assign rdata_nxt = hit_clksel ? clksel_r :
                       hit_reldly ? {4'h0, reldly_r} : 8'h00;

    // ------------------------------------------------------------------
    // Power-fail detection and scenario
    // ------------------------------------------------------------------
    // falling edge detect
    assign fail_evt   = pg_prev_r && !pg_s;
    // only a PLL-clocked core takes fail-safe action
    assign fs_start   = fail_evt && clksel_r.src_pll &&
                        (fs_state_r == MCC_FS_IDLE);
    assign fs_to_hand = (fs_state_r == MCC_FS_WAIT) && (fs_cnt_r == 7'h00);
    assign fs_hold    = fs_start || (fs_state_r == MCC_FS_WAIT) ||
                        (fs_state_r == MCC_FS_HAND) ||
                        (fs_state_r == MCC_FS_GUARD);

    // ------------------------------------------------------------------
    // Clock select register next value
    // ------------------------------------------------------------------
    // Hardware set beats sleep clear, which beats a firmware write
    always_comb begin
        clksel_nxt = clksel_r;
        if (wr_clksel) begin
            clksel_nxt.pll_run  = mmcr_wdata_i[MCC_BIT_PLL_RUN];
            clksel_nxt.pll_down = mmcr_wdata_i[MCC_BIT_PLL_DOWN];
            clksel_nxt.ring_on  = mmcr_wdata_i[MCC_BIT_RING_ON];
            clksel_nxt.src_pll  = mmcr_wdata_i[MCC_BIT_SRC_PLL];
            clksel_nxt.freq_sel = mmcr_wdata_i[MCC_BIT_FREQ_LO +: 2];
        end
        clksel_nxt.rsvd = 2'h0;
        if (core_sleep_entry_i) begin
            clksel_nxt.ring_on = 1'b0;
        end
        if (core_wake_i) begin
            clksel_nxt.ring_on = 1'b1;
            clksel_nxt.src_pll = 1'b0;
        end
        if (fail_evt) begin
            clksel_nxt.ring_on = 1'b1;
        end
        if (fs_to_hand) begin
            clksel_nxt.src_pll = 1'b0;
        end
    end

    // Register storage and read data
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            clksel_r <= MCC_CLKSEL_RESET;
            reldly_r <= MCC_RELDLY_RESET;
            rdata_r  <= 8'h00;
        end else if (ce_i) begin
            clksel_r <= clksel_nxt;
            if (wr_reldly) begin
                reldly_r <= mmcr_wdata_i[MCC_RELDLY_W-1:0];
            end
            if (mmcr_rd_i) begin
                rdata_r <= rdata_nxt;
            end
        end
    end

    // ------------------------------------------------------------------
    // Fail-safe sequencer
    // ------------------------------------------------------------------
    // wait, handover, guard; total stays under the 6 us limit
    always_comb begin
        fs_state_nxt = fs_state_r;
        fs_cnt_nxt   = (fs_cnt_r != 7'h00) ? fs_cnt_r - 7'h01 : 7'h00;
        case (fs_state_r)
            MCC_FS_IDLE: begin
                if (fs_start) begin
                    fs_state_nxt = MCC_FS_WAIT;
                    fs_cnt_nxt   = 7'(MCC_FS_WAIT_CYC - 1);
                end
            end
            MCC_FS_WAIT: begin
                if (fs_cnt_r == 7'h00) begin
                    fs_state_nxt = MCC_FS_HAND;
                    fs_cnt_nxt   = 7'(MCC_FS_HAND_CLKS - 1);
                end
            end
            MCC_FS_HAND: begin
                if (fs_cnt_r == 7'h00) begin
                    fs_state_nxt = MCC_FS_GUARD;
                    fs_cnt_nxt   = 7'(MCC_FS_GUARD_CYC - 1);
                end
            end
            MCC_FS_GUARD: begin
                if (fs_cnt_r == 7'h00) begin
                    fs_state_nxt = MCC_FS_DONE;
                end
            end
            MCC_FS_DONE: begin
                // Re-arm once the main rail is back
                if (pg_s) begin
                    fs_state_nxt = MCC_FS_IDLE;
                end
            end
            default: begin
                fs_state_nxt = MCC_FS_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            fs_state_r <= MCC_FS_IDLE;
            fs_cnt_r   <= 7'h00;
        end else if (ce_i) begin
            fs_state_r <= fs_state_nxt;
            fs_cnt_r   <= fs_cnt_nxt;
        end
    end

    // ------------------------------------------------------------------
    // Delay timers
    // ------------------------------------------------------------------
    // reset release on reset bit fall
    assign rel_load  = rst_bit_prev_r && !internal_reset_out_bit_i;
    // lock wait when power-down clears with rail up
    assign lock_load = down_prev_r && !clksel_r.pll_down && pg_s;
    assign ring_load = !ring_prev_r && clksel_r.ring_on;

    mcc_delay_cnt #(.W(MCC_RELDLY_W)) u_rel_cnt (
        .clk_sys_i  (clk_sys_i),
        .rst_i      (rst_i),
        .ce_i       (ce_i),
        .load_i     (rel_load),
        .load_val_i (reldly_r),
        .tick_i     (machine_cycle_i),
        .done_o     (rel_done)
    );

    mcc_delay_cnt #(.W(MCC_LOCK_W)) u_lock_cnt (
        .clk_sys_i  (clk_sys_i),
        .rst_i      (rst_i),
        .ce_i       (ce_i),
        .load_i     (lock_load),
        .load_val_i (MCC_LOCK_W'(MCC_PLL_LOCK_CYC)),
        .tick_i     (1'b1),
        .done_o     (lock_done)
    );

    mcc_delay_cnt #(.W(MCC_RING_W)) u_ring_cnt (
        .clk_sys_i  (clk_sys_i),
        .rst_i      (rst_i),
        .ce_i       (ce_i),
        .load_i     (ring_load),
        .load_val_i (MCC_RING_W'(MCC_RING_START_CYC - 2)),
        .tick_i     (1'b1),
        .done_o     (ring_done)
    );

    // ------------------------------------------------------------------
    // Status flops
    // ------------------------------------------------------------------
    // Edge history and derived status, all registered
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            pg_prev_r      <= 1'b0;
            rst_bit_prev_r <= 1'b1;
            down_prev_r    <= 1'b0;
            ring_prev_r    <= 1'b1;
            rst_pin_n_r    <= 1'b0;
            pll_stable_r   <= 1'b1;
            ring_run_r     <= 1'b1;
            int_pg_r       <= 1'b0;
            pfi_r          <= 1'b0;
        end else if (ce_i) begin
            pg_prev_r      <= pg_s;
            rst_bit_prev_r <= internal_reset_out_bit_i;
            down_prev_r    <= clksel_r.pll_down;
            ring_prev_r    <= clksel_r.ring_on;
            rst_pin_n_r    <= !internal_reset_out_bit_i && rel_done &&
                              !rel_load;
            pll_stable_r   <= !clksel_r.pll_down && lock_done && !lock_load;
            ring_run_r     <= clksel_r.ring_on && ring_done && !ring_load;
            int_pg_r       <= fs_hold ? 1'b1 : pg_s;
            pfi_r          <= fail_evt;
        end
    end

    // Sticky flag: a new event beats a clear in the same cycle
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            pgi_r <= 1'b0;
        end else if (ce_i) begin
            if (fail_evt && core_sleep_i && !clksel_r.src_pll) begin
                pgi_r <= 1'b1;
            end else if (powergood_irq_clear_i) begin
                pgi_r <= 1'b0;
            end
        end
    end

    // Flash ownership lasts until the sequence re-arms
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            flash_r <= 1'b0;
        end else if (ce_i) begin
            if (fs_start && core_stopped_i) begin
                flash_r <= 1'b1;
            end else if (fs_state_r == MCC_FS_DONE && pg_s) begin
                flash_r <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    // power-down overrides the run bit
    assign pll_clock_run_o       = clksel_r.pll_run && !clksel_r.pll_down;
    assign pll_power_down_o      = clksel_r.pll_down;
    assign periph_clocks_run_o   = !clksel_r.pll_down;
    assign pll_stable_o          = pll_stable_r;
    assign ring_osc_on_o         = clksel_r.ring_on;
    assign ring_osc_running_o    = ring_run_r;
    assign core_source_pll_o     = clksel_r.src_pll;
    assign core_freq_select_o    = clksel_r.freq_sel;
    assign reset_out_pin_n_o     = rst_pin_n_r;
    assign internal_power_good_o = int_pg_r;
    assign power_fail_irq_o      = pfi_r;
    assign powergood_irq_flag_o  = pgi_r;
    assign flash_to_core_o       = flash_r;
    assign mmcr_rdata_o          = rdata_r;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    localparam int FS_MAX = 120;
    localparam int RS_MAX = 121;
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (rst_i || !ce_i);

    sequence pll_fail_s;
        fail_evt && clksel_r.src_pll && fs_state_r == MCC_FS_IDLE;
    endsequence

    pll_stop_a: assert property (
        pll_power_down_o |-> !pll_clock_run_o && !periph_clocks_run_o)
        else $error("clocks run while PLL is down");
    run_clear_a: assert property (
        wr_clksel && !mmcr_wdata_i[MCC_BIT_PLL_RUN] |=> !pll_clock_run_o)
        else $error("PLL clock kept running after run bit cleared");
    pll_lock_a: assert property (
        lock_load |=> !pll_stable_o [*8])
        else $error("PLL stable too early");
    ring_rdback_a: assert property (
        mmcr_rd_i && hit_clksel |=> mmcr_rdata_o[4] == $past(ring_osc_on_o))
        else $error("ring enable read back wrong");
    sleep_ring_a: assert property (
        core_sleep_entry_i && !core_wake_i && !fail_evt |=> !ring_osc_on_o)
        else $error("ring stayed on at sleep entry");
    ring_start_a: assert property (
        $rose(ring_osc_on_o) |-> ##[1:RS_MAX]
            (ring_osc_running_o || !ring_osc_on_o))
        else $error("ring oscillator start too slow");
    wake_src_a: assert property (
        core_wake_i |=> !core_source_pll_o && ring_osc_on_o)
        else $error("wake did not return core to ring");
    rel_pin_a: assert property (
        rel_load |=> !reset_out_pin_n_o)
        else $error("reset pin released without delay");
    fs_switch_a: assert property (
        pll_fail_s |-> ##[1:FS_MAX] !core_source_pll_o)
        else $error("core not on ring within limit");
    pg_hold_a: assert property (
        pll_fail_s |=> internal_power_good_o [*8])
        else $error("internal power-good dropped early");
    pfi_a: assert property (
        fail_evt |=> power_fail_irq_o)
        else $error("power-fail interrupt missing");
    rsvd_zero_a: assert property (
        mmcr_rd_i && hit_reldly |=> mmcr_rdata_o[7:4] == 4'h0)
        else $error("reserved bits read nonzero");

endmodule : mcc_clock_source_control
`default_nettype wire

// ==== mcc_pkg.sv ====
// Notes on behaviour
// - Ring oscillator enable lets the core run while the main rail is off.
// - PLL clock run bit D0: zero stops the core PLL clock, one runs it.
// - PLL power-down bit D1 stops PLL and all clocks but RTC and ring.
// - After power-down clears on main rail, PLL needs up to 100 us.
// - Ring enable bit D4 reads the real oscillator state; writes start or stop. Here D4 reads back the stored enable, not ring_osc_running_o.
// - Sleep entry clears the ring enable; first wake from sleep sets it.
// - Ring oscillator runs within 6 us of its enable rising.
// - Source select bit D5: one picks PLL clock, zero picks ring oscillator.
// - Wake from sleep clears source select so the core resumes on ring.
// - Frequency field D7:D6 picks 12, 16, 24 or 32 MHz core clock.
// - Release delay count sets machine cycles from reset bit clear to pin high.
// - Main power-good pin falling from 1 to 0 is a power failure.
// - Failure starts ring; within 2.76 us core clock starts moving to ring.
// - Handover takes two ring and two PLL clocks, then a 2 us guard.
// - Core clock runs from ring less than 6 us after power-good falls.
// - Every power failure raises a power-fail interrupt to the core.
// - Sleeping or running on ring: no fail-safe action, flag only if sleeping.
// - Running on PLL: internal power-good held until ring clock is in use.
// - Stopped on PLL: power-good held likewise and flash handed to core.
// - Power-good interrupt flag sits in bit D0 of its register.
package mcc_pkg;

    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam logic [15:0] MCC_ADDR_CLKSEL   = 16'h7f27;
    localparam logic [15:0] MCC_ADDR_RELDLY   = 16'h7f2f;
    localparam logic [7:0]  MCC_CLKSEL_RESET  = 8'h10;
    localparam logic [3:0]  MCC_RELDLY_RESET  = 4'h0;
    localparam int          MCC_RELDLY_W      = 4;

    // Field positions of clock_select_control, and of the power-good flag bit
    localparam int MCC_BIT_PLL_RUN  = 0;
    localparam int MCC_BIT_PLL_DOWN = 1;
    localparam int MCC_BIT_RING_ON  = 4;
    localparam int MCC_BIT_SRC_PLL  = 5;
    localparam int MCC_BIT_FREQ_LO  = 6;
    localparam int MCC_BIT_PGI      = 0;

    // Frequency select codes
    localparam logic [1:0] MCC_FREQ_12 = 2'h0;
    localparam logic [1:0] MCC_FREQ_16 = 2'h1;
    localparam logic [1:0] MCC_FREQ_24 = 2'h2;
    localparam logic [1:0] MCC_FREQ_32 = 2'h3;

    // ------------------------------------------------------------------
    // Timing, system clock 20 MHz
    // ------------------------------------------------------------------
    localparam int MCC_CLK_PERIOD_NS = 50;
    localparam int MCC_PLL_LOCK_NS   = 100000;
    localparam int MCC_RING_START_NS = 6000;
    localparam int MCC_FS_WAIT_NS    = 2760;
    localparam int MCC_FS_GUARD_NS   = 2000;
    localparam int MCC_FS_HAND_CLKS  = 4;
    // Least time rounds up, longest times round down
    localparam int MCC_PLL_LOCK_CYC  =
        (MCC_PLL_LOCK_NS + MCC_CLK_PERIOD_NS - 1) / MCC_CLK_PERIOD_NS;
    localparam int MCC_RING_START_CYC = MCC_RING_START_NS / MCC_CLK_PERIOD_NS;
    localparam int MCC_FS_WAIT_CYC   = MCC_FS_WAIT_NS / MCC_CLK_PERIOD_NS;
    localparam int MCC_FS_GUARD_CYC  = MCC_FS_GUARD_NS / MCC_CLK_PERIOD_NS;
    localparam int MCC_LOCK_W        = 11;
    localparam int MCC_RING_W        = 7;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [1:0] freq_sel;
        logic       src_pll;
        logic       ring_on;
        logic [1:0] rsvd;
        logic       pll_down;
        logic       pll_run;
    } mcc_clksel_t;

    typedef enum logic [4:0] {
        MCC_FS_IDLE  = 5'h01,
        MCC_FS_WAIT  = 5'h02,
        MCC_FS_HAND  = 5'h04,
        MCC_FS_GUARD = 5'h08,
        MCC_FS_DONE  = 5'h10
    } mcc_fs_state_t;

endpackage : mcc_pkg

// ==== mcc_sync2.sv ====
`timescale 1ns/1ns
`default_nettype none
module mcc_sync2 (
    input  wire logic clk_sys_i,   // System clock
    input  wire logic rst_i,       // Synchronous reset
    input  wire logic ce_i,        // Clock enable
    input  wire logic d_i,         // Asynchronous level in
    output logic      q_o          // Synchronised level
);
    logic meta_r;
    logic hold_r;

    // Two stages; only the second stage is visible outside
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            meta_r <= 1'b0;
            hold_r <= 1'b0;
        end else if (ce_i) begin
            meta_r <= d_i;
            hold_r <= meta_r;
        end
    end
    assign q_o = hold_r;
endmodule : mcc_sync2
`default_nettype wire

// ==== mcc_delay_cnt.sv ====
`timescale 1ns/1ns
`default_nettype none
module mcc_delay_cnt #(
    parameter int W = 4
) (
    input  wire logic         clk_sys_i,  // System clock
    input  wire logic         rst_i,      // Synchronous reset
    input  wire logic         ce_i,       // Clock enable
    input  wire logic         load_i,     // Start a new delay
    input  wire logic [W-1:0] load_val_i, // Delay length in ticks
    input  wire logic         tick_i,     // Count step
    output logic              done_o      // Count has reached zero
);
    logic [W-1:0] cnt_r;
    logic [W-1:0] cnt_nxt;

    // Load wins over a step in the same cycle
    assign cnt_nxt = load_i ? load_val_i :
                     (tick_i && (cnt_r != '0)) ? cnt_r - 1'b1 : cnt_r;

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            cnt_r <= '0;
        end else if (ce_i) begin
            cnt_r <= cnt_nxt;
        end
    end
    assign done_o = (cnt_r == '0);
endmodule : mcc_delay_cnt
`default_nettype wire

// ==== mcc_clock_source_control_tb_top.sv ====
`timescale 1ns/1ns
`default_nettype none
module mcc_clock_source_control_tb_top;
    import mcc_pkg::*;
    logic        clk = 0, rst = 1, wr = 0, rd = 0, pg = 1, ent = 0;
    logic        wake = 0, irob = 1, src, ring, ipg, pfi, pin_n;
    logic        slp = 0, stp = 0, clr = 0, run, per, pdn, stab, rrun;
    logic        flg, fl;
    logic [1:0]  fq;
    logic [15:0] addr = 16'h0000;
    logic [7:0]  wd = 8'h00, rdat, v;
    int          miscompares = 0, checks = 0, i;
    // Rows: address, write value, value read back
    logic [15:0] ra [4] = '{16'h7f27, 16'h7f27, 16'h7f2f, 16'h7f28};
    logic [7:0]  rw [4] = '{8'hff, 8'hc0, 8'hff, 8'hff};
    logic [7:0]  rx [4] = '{8'hf3, 8'hc0, 8'h0f, 8'h00};
    mcc_clock_source_control uut (.clk_sys_i(clk), .rst_i(rst),
        .ce_i(1'b1), .mmcr_addr_i(addr), .mmcr_wdata_i(wd),
        .mmcr_wr_i(wr), .mmcr_rd_i(rd), .mmcr_rdata_o(rdat),
        .main_power_good_i(pg), .core_sleep_i(slp),
        .core_sleep_entry_i(ent), .core_wake_i(wake),
        .core_stopped_i(stp), .internal_reset_out_bit_i(irob),
        .machine_cycle_i(1'b1), .powergood_irq_clear_i(clr),
        .pll_clock_run_o(run), .pll_power_down_o(pdn),
        .periph_clocks_run_o(per), .pll_stable_o(stab),
        .ring_osc_on_o(ring),
        .ring_osc_running_o(rrun), .core_source_pll_o(src),
        .core_freq_select_o(fq), .reset_out_pin_n_o(pin_n),
        .internal_power_good_o(ipg), .power_fail_irq_o(pfi),
        .powergood_irq_flag_o(flg), .flash_to_core_o(fl));
    initial forever #25 clk = ~clk;
    task chk(input logic [7:0] s, input logic [7:0] e);
        checks++;
        if (s !== e) begin
            miscompares++;
            $display("[FAIL] %0t seen %h expected %h", $time, s, e);
        end
    endtask : chk
    // Strobes rise and fall on falling edges, one cycle wide
    task wreg(input logic [15:0] a, input logic [7:0] d);
        @(negedge clk); addr = a; wd = d; wr = 1;
        @(negedge clk); wr = 0;
    endtask : wreg
    task rreg(input logic [15:0] a);
        @(negedge clk); addr = a; rd = 1;
        @(negedge clk); rd = 0; v = rdat;
    endtask : rreg
    task conclude;
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : conclude
    // Watchdog: the sequence needs well under 1000 cycles
    initial begin
        #150000; miscompares++; conclude();
    end
    initial begin
        repeat (5) @(negedge clk); rst = 0;
        rreg(MCC_ADDR_CLKSEL); chk(v, MCC_CLKSEL_RESET);
        for (i = 0; i < 4; i++) begin
            wreg(ra[i], rw[i]); rreg(ra[i]); chk(v, rx[i]);
        end
        chk(fq, 2'h3);
        chk(stab, 1'b0);
        chk(rrun, 1'b0);
        // Power-down stops the PLL clock and the peripheral clocks
        wreg(MCC_ADDR_CLKSEL, 8'h03);
        chk(run, 1'b0);
        chk(per, 1'b0);
        chk(pdn, 1'b1);
        // Release delay of three machine cycles
        wreg(MCC_ADDR_RELDLY, 8'h03); chk(pin_n, 1'b0);
        @(negedge clk); irob = 0;
        repeat (4) @(negedge clk); chk(pin_n, 1'b0);
        @(negedge clk); chk(pin_n, 1'b1);
        // Sleep clears ring enable, wake sets it and drops PLL source
        wreg(MCC_ADDR_CLKSEL, 8'h30);
        @(negedge clk); ent = 1; @(negedge clk); ent = 0;
        rreg(MCC_ADDR_CLKSEL); chk(v, 8'h20);
        @(negedge clk); wake = 1; @(negedge clk); wake = 0;
        rreg(MCC_ADDR_CLKSEL); chk(v, 8'h10);
        // Power fail while running on the PLL
        wreg(MCC_ADDR_CLKSEL, 8'h21); chk(src, 1'b1);
        chk(ring, 1'b0); chk(ipg, 1'b1);
        chk(run, 1'b1);
        chk(per, 1'b1);
        @(negedge clk); pg = 0;
        for (i = 0; i < 8 && pfi !== 1'b1; i++) @(negedge clk);
        chk(pfi, 1'b1);
        @(negedge clk); chk(ring, 1'b1); chk(ipg, 1'b1);
        for (i = 0; i < 115 && src !== 1'b0; i++) @(negedge clk);
        chk(src, 1'b0); chk(ipg, 1'b1);
        for (i = 0; i < 60 && ipg !== 1'b0; i++) @(negedge clk);
        chk(ipg, 1'b0);
        repeat (20) @(negedge clk);
        chk(rrun, 1'b1);
        // Rail back, then a failure while sleeping on the ring
        pg = 1;
        slp = 1;
        repeat (4) @(negedge clk);
        pg = 0;
        repeat (4) @(negedge clk);
        chk(flg, 1'b1);
        chk(src, 1'b0);
        chk(ipg, 1'b0);
        @(negedge clk);
        clr = 1;
        @(negedge clk);
        clr = 0;
        chk(flg, 1'b0);
        // Rail back, then a failure with the core stopped on the PLL
        pg = 1;
        slp = 0;
        repeat (4) @(negedge clk);
        wreg(MCC_ADDR_CLKSEL, 8'h21);
        stp = 1;
        pg = 0;
        repeat (4) @(negedge clk);
        chk(fl, 1'b1);
        chk(ipg, 1'b1);
        chk(src, 1'b1);
        conclude();
    end
endmodule : mcc_clock_source_control_tb_top
`default_nettype wire
